// File: design/uart_core_consts.vh
// Purpose: Constants for the serial transceiver core.
// Assumes: 40 MHz clock, 32-bit register bus with byte addresses.
// Notes: Register offsets, field positions, reset values and timing counts.
`ifndef UART_CORE_CONSTS_VH
`define UART_CORE_CONSTS_VH

// Register byte offsets.
`define OFS_CTRL 8'h00
`define OFS_ENABLE 8'h04
`define OFS_STATUS 8'h08
`define OFS_RXBUF 8'h0c
`define OFS_TXBUF 8'h10
`define OFS_DIV_LO 8'h14
`define OFS_DIV_HI 8'h18
`define OFS_MODPAT 8'h1c

// Control register fields.
`define CTRL_SOFTWARE_RESET_BIT 0
`define CTRL_CHAR8 1
`define CTRL_PAR_EN 2
`define CTRL_PAR_EVEN 3
`define CTRL_TWO_STOP 4
`define CTRL_ADDR_MODE 5
`define CTRL_ACCEPT_ERR 6
`define CTRL_WAKE_FILT 7
`define CTRL_RST 8'h01

// Enable register fields.
`define EN_RX 0
`define EN_TX 1

// Status register fields.
`define ST_FE 0
`define ST_PE 1
`define ST_OE 2
`define ST_BRK 3
`define ST_ERR 4
`define ST_RXIRQ 5
`define ST_TXRDY 6
`define ST_TXEMPTY 7
`define ST_RXBUSY 8

// Reset values of the divisor and modulation pattern.
`define DIV_LO_RST 8'h03
`define DIV_HI_RST 8'h00
`define MODPAT_RST 8'h00

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Timing.
`define CLK_PERIOD_NS 25
`define DEGLITCH_NS 300
`define DEGLITCH_CYC ((`DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BREAK_BITS 10

`endif

// File: design/uart_rx_tx_baud_core.v
// Purpose: Asynchronous serial transceiver with fractional baud generator.
// Assumes: The bus clock is also the baud source clock; divisor at least 3.
// Notes: Registers are reached over AXI4-Lite; one write and one read at a time.
`timescale 1ns/1ps
`default_nettype none
`include "uart_core_consts.vh"

module uart_rx_tx_baud_core (
	// Clock and reset
	input wire clk,
	input wire rst,
	// AXI4-Lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Serial lines
	input wire serial_rx_line,
	output reg serial_tx_line
);

	localparam R_IDLE = 2'd0;
	localparam R_BITS = 2'd1;
	localparam R_BRK = 2'd2;

	function is_mapped;
		input [7:0] a;
		begin
			is_mapped = (a[1:0] == 2'b00) && (a <= `OFS_MODPAT);
		end
	endfunction

	reg [7:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg [7:0] ctrl_q;
	reg [1:0] en_q;
	reg [7:0] div_lo_q;
	reg [7:0] div_hi_q;
	reg [7:0] modpat_q;
	reg [8:0] txbuf_q;
	reg tx_full_q;
	reg tx_go_q;
	reg [8:0] rxbuf_q;
	reg fe_q, pe_q, oe_q, brk_q, err_q, rxirq_q;
	reg rx_s1_q, rx_s2_q, rx_s3_q, rx_cl_q;
	reg [1:0] rx_st_q;
	reg [3:0] rx_idx_q;
	reg [3:0] dg_q;
	reg [3:0] low_q;
	reg [2:0] sm_q;
	reg [9:0] rx_sh_q;
	reg tx_busy_q;
	reg [12:0] tx_sh_q;
	reg [3:0] tx_left_q;

	wire software_reset_bit = ctrl_q[`CTRL_SOFTWARE_RESET_BIT];
	wire char8 = ctrl_q[`CTRL_CHAR8];
	wire par_en = ctrl_q[`CTRL_PAR_EN];
	wire par_even = ctrl_q[`CTRL_PAR_EVEN];
	wire addr_md = ctrl_q[`CTRL_ADDR_MODE];
	wire [15:0] div = {div_hi_q, div_lo_q};

	wire wr_do = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire wr_lo = wr_do && w_strb_q[0];
	wire rd_go = s_axi_arvalid && s_axi_arready;
	wire rd_rxbuf = rd_go && (s_axi_araddr == `OFS_RXBUF);
	wire wr_status = wr_lo && (aw_addr_q == `OFS_STATUS);
	wire wr_txbuf = wr_lo && (aw_addr_q == `OFS_TXBUF) && !software_reset_bit;

	// Bit timers: index 0 for the receiver, 1 for the transmitter.
	wire [1:0] tm_go;
	wire [1:0] tm_on;
	wire [1:0] bit_end;
	wire [1:0] samp;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_tmr
			reg [15:0] cnt_q;
			reg first_q;
			reg [2:0] mi_q;
			wire [15:0] half = div >> 1;
			wire [15:0] half2 = div - half + {15'h0000, modpat_q[mi_q]};
			// divisor of 3 or more keeps both halves non-empty
			assign bit_end[gi] = tm_on[gi] && !tm_go[gi] && !first_q && (cnt_q == 16'h0001);
			assign samp[gi] = tm_on[gi] && !tm_go[gi] &&
				((first_q && cnt_q == 16'h0001) ||
				(!first_q && (cnt_q == half2 || cnt_q == half2 - 16'h0001)));
			always @(posedge clk) begin
				if (rst) begin
					cnt_q <= 16'h0000;
					first_q <= 1'b1;
					mi_q <= 3'h0;
				end else if (tm_go[gi]) begin
					cnt_q <= half;
					first_q <= 1'b1;
					mi_q <= 3'h0;
				end else if (tm_on[gi]) begin
					if (cnt_q == 16'h0001) begin
						if (first_q) begin
							cnt_q <= half2;
							first_q <= 1'b0;
						end else begin
							cnt_q <= half;
							first_q <= 1'b1;
							mi_q <= mi_q + 3'h1;
						end
					end else begin
						cnt_q <= cnt_q - 16'h0001;
					end
				end
			end
		end
	endgenerate

	// Receive line synchroniser; a change counts once stages two and three agree.
	always @(posedge clk) begin
		if (rst) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			rx_s3_q <= 1'b1;
			rx_cl_q <= 1'b1;
		end else begin
			rx_s1_q <= serial_rx_line;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
			if (rx_s2_q == rx_s3_q) begin
				rx_cl_q <= rx_s3_q;
			end
		end
	end

	// Receive frame decode.
	wire rx_start = (rx_st_q == R_IDLE) && !software_reset_bit && en_q[`EN_RX] && !rx_cl_q;
	assign tm_go[0] = rx_start;
	assign tm_on[0] = (rx_st_q != R_IDLE);
	wire [2:0] sv = samp[0] ? {sm_q[1:0], rx_cl_q} : sm_q;
	wire vote = (sv[0] & sv[1]) | (sv[0] & sv[2]) | (sv[1] & sv[2]);
	// bits between the start bit and the stop bit
	wire [3:0] nb = (char8 ? 4'd8 : 4'd7) + {3'h0, addr_md} + {3'h0, par_en};
	wire [9:0] rx_al = rx_sh_q >> (4'd10 - nb);
	wire [8:0] rx_word = {addr_md & (char8 ? rx_al[8] : rx_al[7]),
		char8 ? rx_al[7:0] : {1'b0, rx_al[6:0]}};
	wire at_stop = (rx_st_q == R_BITS) && bit_end[0] && (rx_idx_q == nb + 4'd1);
	wire fe_now = !vote;
	wire pe_now = par_en && ((^rx_al) ^ ~par_even);
	// erroneous characters kept only on request
	wire store = at_stop && (ctrl_q[`CTRL_ACCEPT_ERR] || (!fe_now && !pe_now));
	// tenth low bit after missing stop
	wire brk_now = (rx_st_q == R_BRK) && bit_end[0] && !vote &&
		(low_q == `BREAK_BITS - 1);

	always @(posedge clk) begin
		if (rst || software_reset_bit) begin
			rx_st_q <= R_IDLE;
			rx_idx_q <= 4'h0;
			dg_q <= 4'h0;
			low_q <= 4'h0;
			sm_q <= 3'h7;
			rx_sh_q <= 10'h000;
		end else begin
			if (samp[0]) begin
				sm_q <= {sm_q[1:0], rx_cl_q};
			end
			case (rx_st_q)
			R_IDLE: begin
				if (rx_start) begin
					rx_st_q <= R_BITS;
					rx_idx_q <= 4'h0;
					dg_q <= 4'h0;
				end
			end
			R_BITS: begin
				if (rx_idx_q == 4'h0 && dg_q < `DEGLITCH_CYC) begin
					// short low pulse is a glitch
					if (rx_cl_q) begin
						rx_st_q <= R_IDLE;
					end else begin
						dg_q <= dg_q + 4'h1;
					end
				end else if (bit_end[0]) begin
					if (rx_idx_q == 4'h0) begin
						if (vote) begin
							rx_st_q <= R_IDLE;
						end else begin
							rx_idx_q <= 4'h1;
						end
					end else if (rx_idx_q <= nb) begin
						rx_sh_q <= {vote, rx_sh_q[9:1]};
						rx_idx_q <= rx_idx_q + 4'h1;
					end else if (fe_now && rx_al == 10'h000) begin
						rx_st_q <= R_BRK;
						low_q <= 4'h0;
					end else begin
						rx_st_q <= R_IDLE;
					end
				end
			end
			R_BRK: begin
				if (bit_end[0]) begin
					if (vote) begin
						rx_st_q <= R_IDLE;
					end else if (low_q < `BREAK_BITS) begin
						low_q <= low_q + 4'h1;
					end
				end
			end
			default: begin
				rx_st_q <= R_IDLE;
			end
			endcase
		end
	end

	// Receive flags: hardware set wins over any clear in the same cycle.
	wire [5:0] fl_q = {rxirq_q, err_q, brk_q, oe_q, pe_q, fe_q};
	wire [5:0] fl_clr = rd_rxbuf ? 6'h3f : (wr_status ? w_data_q[5:0] : 6'h00);
	wire oe_now = store && rxirq_q && !rd_rxbuf;
	wire fe_set = at_stop && fe_now;
	wire pe_set = at_stop && pe_now;
	wire err_set = fe_set | pe_set | oe_now | brk_now;
	wire [5:0] fl_set = {store | brk_now, err_set, brk_now, oe_now, pe_set, fe_set};
	wire [5:0] fl_d = (fl_q & ~fl_clr) | fl_set;

	always @(posedge clk) begin
		if (rst || software_reset_bit) begin
			{rxirq_q, err_q, brk_q, oe_q, pe_q, fe_q} <= 6'h00;
			rxbuf_q <= 9'h000;
		end else begin
			{rxirq_q, err_q, brk_q, oe_q, pe_q, fe_q} <= fl_d;
			if (store) begin
				rxbuf_q <= rx_word;
			end
		end
	end

	// Transmit frame build.
	reg [12:0] tf;
	reg [3:0] pos;
	reg tpar;
	always @* begin
		tf = 13'h1fff;
		tf[0] = 1'b0;
		tf[8:1] = char8 ? txbuf_q[7:0] : {1'b1, txbuf_q[6:0]};
		tpar = ^(char8 ? txbuf_q[7:0] : {1'b0, txbuf_q[6:0]}) ^ (addr_md & txbuf_q[8]);
		pos = char8 ? 4'd9 : 4'd8;
		if (addr_md) begin
			tf[pos] = txbuf_q[8];
			pos = pos + 4'd1;
		end
		if (par_en) begin
			tf[pos] = par_even ? tpar : ~tpar;
			pos = pos + 4'd1;
		end
		pos = pos + (ctrl_q[`CTRL_TWO_STOP] ? 4'd2 : 4'd1);
	end

	// load once the shifter is empty
	// data buffered while enabled still goes after disable
	wire tx_load = !software_reset_bit && !tx_busy_q && tx_full_q && (en_q[`EN_TX] || tx_go_q);
	assign tm_go[1] = tx_load;
	assign tm_on[1] = tx_busy_q;

	always @(posedge clk) begin
		if (rst || software_reset_bit) begin
			tx_busy_q <= 1'b0;
			tx_sh_q <= 13'h1fff;
			tx_left_q <= 4'h0;
			serial_tx_line <= 1'b1;
		end else begin
			serial_tx_line <= tx_load ? 1'b0 : tx_sh_q[0];
			if (tx_load) begin
				tx_busy_q <= 1'b1;
				tx_sh_q <= tf;
				tx_left_q <= pos;
			end else if (bit_end[1]) begin
				tx_sh_q <= {1'b1, tx_sh_q[12:1]};
				serial_tx_line <= tx_sh_q[1];
				tx_left_q <= tx_left_q - 4'h1;
				if (tx_left_q == 4'h1) begin
					tx_busy_q <= 1'b0;
				end
			end
		end
	end

	// Register writes.
	always @(posedge clk) begin
		if (rst) begin
			ctrl_q <= `CTRL_RST;
			en_q <= 2'h0;
			div_lo_q <= `DIV_LO_RST;
			div_hi_q <= `DIV_HI_RST;
			modpat_q <= `MODPAT_RST;
			txbuf_q <= 9'h000;
			tx_full_q <= 1'b0;
			tx_go_q <= 1'b0;
		end else begin
			if (wr_lo) begin
				case (aw_addr_q)
				`OFS_CTRL: ctrl_q <= w_data_q[7:0];
				`OFS_ENABLE: en_q <= w_data_q[1:0];
				`OFS_DIV_LO: div_lo_q <= w_data_q[7:0];
				`OFS_DIV_HI: div_hi_q <= w_data_q[7:0];
				`OFS_MODPAT: modpat_q <= w_data_q[7:0];
				default: ;
				endcase
			end
			if (software_reset_bit) begin
				// ready and empty set, enables kept
				tx_full_q <= 1'b0;
				tx_go_q <= 1'b0;
			end else if (wr_txbuf) begin
				txbuf_q <= {w_strb_q[1] & w_data_q[8], w_data_q[7:0]};
				tx_full_q <= 1'b1;
				tx_go_q <= en_q[`EN_TX];
			end else if (tx_load) begin
				tx_full_q <= 1'b0;
				tx_go_q <= 1'b0;
			end
		end
	end

	// Read mux.
	reg [31:0] rd_val;
	always @* begin
		rd_val = 32'h00000000;
		case (s_axi_araddr)
		`OFS_CTRL: rd_val[7:0] = ctrl_q;
		`OFS_ENABLE: rd_val[1:0] = en_q;
		`OFS_STATUS: rd_val[8:0] = {rx_st_q != R_IDLE, !tx_busy_q && !tx_full_q,
			!tx_full_q, fl_q};
		`OFS_RXBUF: rd_val[8:0] = rxbuf_q;
		`OFS_DIV_LO: rd_val[7:0] = div_lo_q;
		`OFS_DIV_HI: rd_val[7:0] = div_hi_q;
		`OFS_MODPAT: rd_val[7:0] = modpat_q;
		default: rd_val = 32'h00000000;
		endcase
	end

	// AXI4-Lite handshakes.
	always @(posedge clk) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_do) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (rd_go) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // uart_rx_tx_baud_core
`default_nettype wire

// File: test/serial_far_end.sv
// Purpose: Far serial device that sends and captures frames.
// Assumes: Divisor and pattern mirror the core's registers.
// Notes: The line idles high.
`timescale 1ns/1ps
`default_nettype none
module serial_far_end (
	// Clock and settings
	input wire logic clk,
	input wire logic [15:0] div,
	input wire logic [7:0] modpat,
	// Serial lines
	input wire logic tx_line,
	output logic rx_line,
	// Captured frame
	output logic [9:0] got_bits,
	output int got_cnt
);
	function automatic int blen(input int i);
		return div + modpat[i % 8];
	endfunction
	initial begin
		rx_line = 1'b1;
		got_bits = 10'h0;
		got_cnt = 0;
	end
	task automatic send(input logic [23:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			rx_line <= b[i];
			repeat (blen(i)) @(posedge clk);
		end
		rx_line <= 1'b1;
	endtask
	task automatic pulse(input int n);
		rx_line <= 1'b0;
		repeat (n) @(posedge clk);
		rx_line <= 1'b1;
	endtask
	always begin
		@(negedge tx_line);
		for (int i = 0; i < 10; i++) begin
			repeat (blen(i) / 2) @(posedge clk);
			got_bits[i] = tx_line;
			repeat (blen(i) - blen(i) / 2) @(posedge clk);
		end
		got_cnt++;
	end
endmodule // serial_far_end
`default_nettype wire

// File: test/uart_core_checker.sv
// Purpose: Port checks for the transceiver core.
// Assumes: Bound to the core, sees its ports only.
// Notes: Bit length bound is the one third clock ceiling.
`timescale 1ns/1ps
`default_nettype none
`include "uart_core_consts.vh"
module uart_core_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Serial
	input wire logic serial_tx_line
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire ar_take = s_axi_arvalid && s_axi_arready;
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
		&& s_axi_awready && s_axi_wready) else $error("write not released");
	a_read_answer: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
		&& s_axi_arready) else $error("read not released");
	a_unmapped_err: assert property (ar_take && s_axi_araddr > `OFS_MODPAT |=>
		s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0)
		else $error("upper read bits set");
	a_tx_min_bit: assert property ($changed(serial_tx_line) |=>
		$stable(serial_tx_line) [*2]) else $error("serial bit too short");
	a_tx_idle_out: assert property ($fell(rst) |-> serial_tx_line)
		else $error("serial output not idle");
endmodule // uart_core_checker
bind uart_rx_tx_baud_core uart_core_checker chk (.*);
`default_nettype wire

// File: test/uart_rx_tx_baud_core_tb_top.sv
// Purpose: Self-checking bench for the transceiver core.
// Assumes: Divisor 24, so a bit outlasts the deglitch window.
// Notes: Registers are reached through AXI4-Lite tasks.
`timescale 1ns/1ps
`default_nettype none
`include "uart_core_consts.vh"
module uart_rx_tx_baud_core_tb_top;
	logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, tx, rx;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0, mp = 8'h0, d, d2;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [1:0] bresp, rresp, r;
	logic [9:0] got;
	int got_cnt, c, err_total = 0, check_count = 0;
	always #12.5 clk = ~clk;
	uart_rx_tx_baud_core dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .serial_rx_line(rx), .serial_tx_line(tx));
	serial_far_end far (.clk(clk), .div(16'h0018), .modpat(mp), .tx_line(tx),
		.rx_line(rx), .got_bits(got), .got_cnt(got_cnt));
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk);
		awaddr <= a;
		wdata <= x;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] e);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		q = rdata;
		e = rresp;
		rready <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a, v, r);
		chk(e, v);
	endtask
	task automatic poll(input int b);
		do rd(`OFS_STATUS, v, r); while (v[b] !== 1'b1);
	endtask
	task automatic got_chk(input logic [7:0] x);
		while (got_cnt == c) @(posedge clk);
		chk({22'h0, 1'b1, x, 1'b0}, {22'h0, got});
		c = got_cnt;
	endtask
	task automatic rx_frame(input logic [23:0] b, input int n);
		@(posedge clk);
		far.send(b, n);
		repeat (60) @(posedge clk);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		err_total++;
		complete_run();
	end
	initial begin
		void'($urandom(32'hae71));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rc(`OFS_CTRL, 32'h1);
		rc(`OFS_STATUS, 32'hc0);
		rc(`OFS_DIV_LO, 32'h3);
		rd(8'h40, v, r);
		chk(`RESP_SLVERR, r);
		wr(8'h40, 32'h0);
		chk(`RESP_SLVERR, r);
		mp = 8'($urandom);
		wr(`OFS_DIV_LO, 32'h18);
		chk(`RESP_OKAY, r);
		wr(`OFS_DIV_HI, 32'h0);
		wr(`OFS_MODPAT, {24'h0, mp});
		wr(`OFS_ENABLE, 32'h3);
		wr(`OFS_CTRL, 32'h2);
		$display("test registers done");
		c = got_cnt;
		for (int i = 0; i < 3; i++) begin
			d = (i == 0) ? 8'hff : 8'($urandom);
			wr(`OFS_TXBUF, {24'h0, d});
			got_chk(d);
		end
		d = 8'($urandom);
		d2 = ~d;
		wr(`OFS_TXBUF, {24'h0, d});
		poll(`ST_TXRDY);
		wr(`OFS_TXBUF, {24'h0, d2});
		wr(`OFS_ENABLE, 32'h1);
		got_chk(d);
		got_chk(d2);
		poll(`ST_TXEMPTY);
		wr(`OFS_TXBUF, {24'h0, d});
		repeat (400) @(posedge clk);
		chk(c, got_cnt);
		wr(`OFS_ENABLE, 32'h3);
		got_chk(d);
		wr(`OFS_CTRL, 32'h0c);
		wr(`OFS_TXBUF, {24'h0, d});
		got_chk({^d[6:0], d[6:0]});
		wr(`OFS_CTRL, 32'h2);
		$display("test transmit done");
		rx_frame({15'h1, d, 1'b0}, 10);
		rc(`OFS_RXBUF, {24'h0, d});
		rx_frame({15'h1, d, 1'b0}, 10);
		rx_frame({15'h1, ~d, 1'b0}, 10);
		rc(`OFS_STATUS, 32'hf4);
		rc(`OFS_RXBUF, {24'h0, ~d});
		rc(`OFS_STATUS, 32'hc0);
		rx_frame({15'h0, d | 8'h01, 1'b0}, 10);
		rc(`OFS_STATUS, 32'hd1);
		wr(`OFS_STATUS, 32'h3f);
		rc(`OFS_STATUS, 32'hc0);
		for (int k = 0; k < 2; k++) begin
			wr(`OFS_CTRL, k ? 32'h4e : 32'h46);
			rx_frame({14'h1, (k ? ~^d : ^d), d, 1'b0}, 11);
			rc(`OFS_STATUS, 32'hf2);
			rc(`OFS_RXBUF, {24'h0, d});
		end
		wr(`OFS_CTRL, 32'h20);
		rx_frame({15'h1, 1'b1, d[6:0], 1'b0}, 10);
		rc(`OFS_RXBUF, {23'h0, 2'b10, d[6:0]});
		wr(`OFS_CTRL, 32'h2);
		rx_frame(24'h0, 22);
		rc(`OFS_STATUS, 32'hf9);
		wr(`OFS_CTRL, 32'h3);
		rc(`OFS_STATUS, 32'hc0);
		rc(`OFS_ENABLE, 32'h3);
		wr(`OFS_CTRL, 32'h2);
		@(posedge clk);
		far.pulse(8);
		repeat (100) @(posedge clk);
		rc(`OFS_STATUS, 32'hc0);
		wr(`OFS_ENABLE, 32'h2);
		rx_frame({15'h1, d, 1'b0}, 10);
		rc(`OFS_STATUS, 32'hc0);
		$display("test receive done");
		complete_run();
	end
endmodule // uart_rx_tx_baud_core_tb_top
`default_nettype wire
